// ==== byte_fifo.sv ====
`timescale 1ns/1ps

module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic flush,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wptr;
  logic [PTR_W-1:0] rptr;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  // output stage refills whenever it is empty or being taken
  assign pop = (count != '0) && (!out_valid || out_ready);

  always_comb
  begin
    next_count = count;
    if (push && !pop)
    begin
      next_count = count + CNT_W'(1);
    end
    else if (pop && !push)
    begin
      next_count = count - CNT_W'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
    end
    else if (flush)
    begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
    end
    else
    begin
      if (push)
      begin
        wptr <= wptr + PTR_W'(1);
      end
      if (pop)
      begin
        rptr <= rptr + PTR_W'(1);
      end
      count <= next_count;
      // registered so the ready seen upstream never glitches
      in_ready <= (next_count != CNT_W'(DEPTH));
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else if (flush)
    begin
      out_valid <= 1'b0;
    end
    else if (pop)
    begin
      out_valid <= 1'b1;
      out_data <= mem[rptr];
    end
    else if (out_ready)
    begin
      out_valid <= 1'b0;
    end
  end

endmodule

// ==== cassette_ctrl_bus_registers.sv ====
`timescale 1ns/1ps
`include "cassette_ctrl_defines.svh"

// Notes on behaviour
// - respond only with upper five ones, sync
// - bits 12 to 3 must match straps
// - bit 2 zero; bit 1 picks register
// - byte buffer sits at next word address
// - address bit 0 ignored for register select
// - byte transfer enables one lane by bit0
// - C1 high reads register, low writes
// - byte buffer uses only low data byte
// - status register write strobes; go bit on low lane launches timing
// - upper byte clocked only by high lane
// - listed bits stored and read back
// - read-only bits show live status, unstored
// - bit 0 write-only launch, never stored
// - drive choice own storage; low bits latched
// - inbound and outbound byte registers separate
// - outbound byte held until write or initialize
// - outbound byte gated off by disable
// - function table from function bits and repeat
// - status table gives error and action enables
// - byte buffer access clears transfer request
// - launch clears ready before sequencing
module cassette_ctrl_bus_registers #(
  parameter logic [16*`FUNC_OUT_W-1:0] FUNC_TABLE = {16{8'h00}},
  parameter logic [256*`STAT_OUT_W-1:0] STATUS_TABLE = {256{4'h0}}
) (
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic [`ADDR_W-1:0] BUS_ADDR,
  input wire logic [`DATA_W-1:0] BUS_DATA_IN,
  output logic [`DATA_W-1:0] BUS_DATA_OUT,
  output logic BUS_DATA_OE,
  input wire logic BUS_MSYN,
  output logic BUS_SSYN,
  input wire logic BUS_C1,
  input wire logic BUS_C0,
  input wire logic BUS_INIT_B,
  input wire logic [`STRAP_W-1:0] ADDR_STRAP,
  input wire logic [`LIVE_W-1:0] LIVE_STATUS,
  input wire logic [`XPORT_STATUS_W-1:0] XPORT_STATUS,
  input wire logic REPEAT_IN,
  input wire logic XPORT_DONE,
  input wire logic XFER_REQ,
  input wire logic OUTBOUND_BYTE_GATE_OFF,
  input wire logic [`BYTE_W-1:0] IN_BYTE,
  input wire logic IN_VALID,
  output logic IN_READY,
  output logic [`BYTE_W-1:0] OUT_BYTE,
  output logic UNIT_SELECT,
  output logic [`FUNC_OUT_W-1:0] FUNC_OUT,
  output logic [`STAT_OUT_W-1:0] ACTION_EN,
  output logic CSR_WRITE_STROBE,
  output logic START_PULSE
);

  import cassette_ctrl_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  localparam int PIN_W = `ADDR_W + `DATA_W + 4 + `STRAP_W;

  logic [PIN_W-1:0] pin_meta;
  logic [PIN_W-1:0] pin_sync;
  logic [`ADDR_W-1:0] addr;
  logic [`DATA_W-1:0] wdata;
  logic msyn;
  logic c1;
  logic c0;
  logic bus_initialize;
  logic [`STRAP_W-1:0] strap;

  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
    end
    else
    begin
      pin_meta <= {BUS_ADDR, BUS_DATA_IN, BUS_MSYN, BUS_C1, BUS_C0, ~BUS_INIT_B, ADDR_STRAP};
      pin_sync <= pin_meta;
    end
  end

  assign {addr, wdata, msyn, c1, c0, bus_initialize, strap} = pin_sync;

  // ----------------------------------------
  // address decode and lanes
  // ----------------------------------------
  logic upper_match;
  logic strap_match;
  logic base_match;
  logic csr_select;
  logic byte_buffer_select;
  logic master_read_dir;
  logic high_lane_enable;
  logic low_lane_enable;
  logic msyn_prev;
  logic cycle_start;

  assign upper_match = (addr[17:13] == `UPPER_ADDR_ONES);
  assign strap_match = (addr[12:3] == strap);
  assign base_match = upper_match && strap_match && msyn && !addr[2];
  // bit 0 deliberately not decoded, so each register answers at both byte addresses of its word
  assign csr_select = base_match && !addr[1];
  assign byte_buffer_select = base_match && addr[1];
  assign master_read_dir = c1;
  assign low_lane_enable = !master_read_dir && (!c0 || !addr[0]);
  assign high_lane_enable = !master_read_dir && (!c0 || addr[0]);
  assign cycle_start = msyn && !msyn_prev && !bus_initialize;

  // ----------------------------------------
  // control/status storage
  // ----------------------------------------
  logic [7:0] csr_low;
  logic unit_sel;
  logic csr_write;
  logic launch;
  logic buf_write;
  logic buf_access;

  assign csr_write = cycle_start && csr_select && !master_read_dir;
  // go is only seen on the low lane, never stored
  assign launch = csr_write && low_lane_enable && wdata[`CSR_GO_BIT];
  assign buf_write = cycle_start && byte_buffer_select && low_lane_enable;
  assign buf_access = cycle_start && byte_buffer_select;

  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      csr_low <= `CSR_LOW_RESET;
    end
    else if (bus_initialize)
    begin
      csr_low <= `CSR_LOW_RESET;
    end
    else if (csr_write && low_lane_enable)
    begin
      csr_low <= wdata[7:0] & `CSR_LOW_STORE_MASK;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      unit_sel <= `CSR_UNIT_RESET;
    end
    else if (bus_initialize)
    begin
      unit_sel <= `CSR_UNIT_RESET;
    end
    else if (csr_write && high_lane_enable)
    begin
      unit_sel <= wdata[`CSR_UNIT_BIT];
    end
  end

  // ----------------------------------------
  // byte buffer halves
  // ----------------------------------------
  logic [`BYTE_W-1:0] outbound_byte;
  logic outbound_byte_clock;
  logic [`BYTE_W-1:0] inbound_byte;
  logic inbound_full;
  logic [`BYTE_W-1:0] fifo_data;
  logic fifo_valid;
  logic fifo_take;
  logic inbound_read;

  assign outbound_byte_clock = buf_write;
  assign inbound_read = buf_access && master_read_dir;
  assign fifo_take = !inbound_full;

  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      outbound_byte <= `OUT_BYTE_RESET;
    end
    else if (bus_initialize)
    begin
      outbound_byte <= `OUT_BYTE_RESET;
    end
    else if (outbound_byte_clock)
    begin
      outbound_byte <= wdata[`BYTE_W-1:0];
    end
  end

  // tape bytes queue here so a slow master does not drop them
  byte_fifo #(
    .WIDTH(`BYTE_W),
    .DEPTH(`FIFO_DEPTH)
  ) u_in_fifo (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .flush(bus_initialize),
    .in_data(IN_BYTE),
    .in_valid(IN_VALID),
    .in_ready(IN_READY),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_take)
  );

  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      inbound_byte <= '0;
      inbound_full <= 1'b0;
    end
    else if (bus_initialize)
    begin
      inbound_full <= 1'b0;
    end
    else if (fifo_valid && !inbound_full)
    begin
      inbound_byte <= fifo_data;
      inbound_full <= 1'b1;
    end
    else if (inbound_read)
    begin
      inbound_full <= 1'b0;
    end
  end

  // ----------------------------------------
  // flags
  // ----------------------------------------
  logic byte_request_flag;
  logic ready_flag;
  logic req_set;

  assign req_set = XFER_REQ || (fifo_valid && !inbound_full);

  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      byte_request_flag <= 1'b0;
    end
    else if (bus_initialize)
    begin
      byte_request_flag <= 1'b0;
    end
    else if (req_set)
    begin
      // a new request in the clearing cycle must survive
      byte_request_flag <= 1'b1;
    end
    else if (buf_access)
    begin
      byte_request_flag <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      ready_flag <= `READY_RESET;
    end
    else if (bus_initialize)
    begin
      ready_flag <= `READY_RESET;
    end
    else if (XPORT_DONE)
    begin
      // completion wins over a launch in the same cycle
      ready_flag <= 1'b1;
    end
    else if (launch)
    begin
      ready_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // command timing
  // ----------------------------------------
  seq_state_t seq_state;
  logic [`SEQ_CNT_W-1:0] seq_cnt;

  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      seq_state <= SEQ_IDLE;
      seq_cnt <= '0;
      START_PULSE <= 1'b0;
    end
    else if (bus_initialize)
    begin
      seq_state <= SEQ_IDLE;
      seq_cnt <= '0;
      START_PULSE <= 1'b0;
    end
    else
    begin
      START_PULSE <= 1'b0;
      case (seq_state)
        SEQ_IDLE:
        begin
          if (launch)
          begin
            seq_state <= SEQ_A;
            seq_cnt <= `SEQ_CNT_W'(`CYC_A - 1);
          end
        end
        SEQ_A:
        begin
          if (seq_cnt == '0)
          begin
            seq_state <= SEQ_B;
            seq_cnt <= `SEQ_CNT_W'(`CYC_B - 1);
          end
          else
          begin
            seq_cnt <= seq_cnt - `SEQ_CNT_W'(1);
          end
        end
        SEQ_B:
        begin
          if (seq_cnt == '0)
          begin
            seq_state <= SEQ_C;
            seq_cnt <= `SEQ_CNT_W'(`CYC_C - 1);
          end
          else
          begin
            seq_cnt <= seq_cnt - `SEQ_CNT_W'(1);
          end
        end
        SEQ_C:
        begin
          if (seq_cnt == '0)
          begin
            seq_state <= SEQ_IDLE;
            START_PULSE <= 1'b1;
          end
          else
          begin
            seq_cnt <= seq_cnt - `SEQ_CNT_W'(1);
          end
        end
        default:
        begin
          seq_state <= SEQ_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // decode tables
  // ----------------------------------------
  logic [2:0] func_sel;
  logic [3:0] func_idx;
  logic [7:0] stat_idx;
  logic [`STAT_OUT_W-1:0] stat_word;

  assign func_sel = csr_low[`CSR_FUNC_MSB:`CSR_FUNC_LSB];
  // repeat is the fourth table input over the three function bits, so all sixteen entries matter
  assign func_idx = {REPEAT_IN, func_sel};
  assign stat_idx = {XPORT_STATUS, func_sel};
  assign stat_word = STATUS_TABLE[{stat_idx, 2'b00} +: `STAT_OUT_W];

  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      FUNC_OUT <= '0;
      ACTION_EN <= '0;
    end
    else
    begin
      FUNC_OUT <= FUNC_TABLE[{func_idx, 3'b000} +: `FUNC_OUT_W];
      ACTION_EN <= stat_word;
    end
  end

  // ----------------------------------------
  // transport-facing outputs
  // ----------------------------------------
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      OUT_BYTE <= '0;
      UNIT_SELECT <= 1'b0;
      CSR_WRITE_STROBE <= 1'b0;
    end
    else
    begin
      OUT_BYTE <= OUTBOUND_BYTE_GATE_OFF ? '0 : outbound_byte;
      UNIT_SELECT <= unit_sel;
      CSR_WRITE_STROBE <= csr_write;
    end
  end

  // ----------------------------------------
  // bus answer
  // ----------------------------------------
  bus_state_t bus_state;
  logic [`DATA_W-1:0] csr_read;
  logic [`DATA_W-1:0] buf_read;

  // status bits are sampled live at the start of the read
  assign csr_read = {stat_word[`STAT_ERR_OUT], LIVE_STATUS, unit_sel, byte_request_flag,
                     csr_low[`CSR_IE_BIT], ready_flag, csr_low[4:1], 1'b0};
  assign buf_read = {8'h00, inbound_byte};

  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      msyn_prev <= 1'b0;
    end
    else
    begin
      msyn_prev <= msyn;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      bus_state <= BUS_IDLE;
      BUS_SSYN <= 1'b0;
      BUS_DATA_OE <= 1'b0;
      BUS_DATA_OUT <= '0;
    end
    else
    begin
      case (bus_state)
        BUS_IDLE:
        begin
          if (cycle_start && (csr_select || byte_buffer_select))
          begin
            bus_state <= BUS_ANSWER;
            BUS_SSYN <= 1'b1;
            BUS_DATA_OE <= master_read_dir;
            BUS_DATA_OUT <= !master_read_dir ? '0 : (csr_select ? csr_read : buf_read);
          end
        end
        BUS_ANSWER:
        begin
          if (!msyn)
          begin
            bus_state <= BUS_IDLE;
            BUS_SSYN <= 1'b0;
            BUS_DATA_OE <= 1'b0;
            BUS_DATA_OUT <= '0;
          end
        end
        default:
        begin
          bus_state <= BUS_IDLE;
        end
      endcase
    end
  end

endmodule

// ==== cassette_ctrl_defines.svh ====
`ifndef CASSETTE_CTRL_DEFINES_SVH
`define CASSETTE_CTRL_DEFINES_SVH

// ----------------------------------------
// address decode
// ----------------------------------------
`define UPPER_ADDR_ONES 5'h1f
`define STRAP_W 10
`define ADDR_W 18
`define DATA_W 16

// ----------------------------------------
// control/status layout
// ----------------------------------------
`define CSR_GO_BIT 0
`define CSR_FUNC_LSB 1
`define CSR_FUNC_MSB 3
`define CSR_READY_BIT 5
`define CSR_IE_BIT 6
`define CSR_REQ_BIT 7
`define CSR_UNIT_BIT 8
`define CSR_LIVE_LSB 9
`define CSR_LIVE_MSB 14
`define CSR_ERR_BIT 15
`define CSR_LOW_STORE_MASK 8'h5e
`define CSR_LOW_RESET 8'h00
`define CSR_UNIT_RESET 1'b0
`define READY_RESET 1'b1
`define OUT_BYTE_RESET 8'h00

// ----------------------------------------
// decode tables
// ----------------------------------------
`define FUNC_OUT_W 8
`define STAT_OUT_W 4
`define STAT_ERR_OUT 3
`define XPORT_STATUS_W 5
`define LIVE_W 6

// ----------------------------------------
// buffering
// ----------------------------------------
`define BYTE_W 8
`define FIFO_DEPTH 16

// ----------------------------------------
// command timing
// ----------------------------------------
`define CLK_MHZ 125
`define NS_PER_US 1000
`define T_PULSE_A_NS 1000
`define T_PULSE_B_NS 1000
`define T_PULSE_C_NS 2000
`define SEQ_CNT_W 9
`define CYC_A ((`T_PULSE_A_NS * `CLK_MHZ + `NS_PER_US - 1) / `NS_PER_US)
`define CYC_B ((`T_PULSE_B_NS * `CLK_MHZ + `NS_PER_US - 1) / `NS_PER_US)
`define CYC_C ((`T_PULSE_C_NS * `CLK_MHZ + `NS_PER_US - 1) / `NS_PER_US)

`endif

// ==== cassette_ctrl_monitor.sv ====
`timescale 1ns/1ps
`include "cassette_ctrl_defines.svh"

module cassette_ctrl_monitor (
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic [`ADDR_W-1:0] BUS_ADDR,
  input wire logic [`DATA_W-1:0] BUS_DATA_OUT,
  input wire logic BUS_DATA_OE,
  input wire logic BUS_MSYN,
  input wire logic BUS_SSYN,
  input wire logic BUS_C1,
  input wire logic BUS_C0,
  input wire logic BUS_INIT_B,
  input wire logic [`STRAP_W-1:0] ADDR_STRAP,
  input wire logic OUTBOUND_BYTE_GATE_OFF,
  input wire logic [`BYTE_W-1:0] OUT_BYTE,
  input wire logic UNIT_SELECT,
  input wire logic CSR_WRITE_STROBE,
  input wire logic START_PULSE
);
  logic hit;
  logic [9:0] since_wr;

  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);

  assign hit = BUS_ADDR[17:13] == `UPPER_ADDR_ONES && BUS_ADDR[12:3] == ADDR_STRAP && !BUS_ADDR[2];

  // ----------------------------------------
  // launch timer
  // ----------------------------------------
  // saturates so a launch with no write behind it is caught
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
      since_wr <= 10'h3ff;
    else if (CSR_WRITE_STROBE)
      since_wr <= 10'h000;
    else if (since_wr != 10'h3ff)
      since_wr <= since_wr + 10'h001;
  end

  // ----------------------------------------
  // bus answer
  // ----------------------------------------
  sequence s_answer;
    ##[2:3] BUS_SSYN;
  endsequence

  sequence s_release;
    ##[1:4] !BUS_SSYN;
  endsequence

  a_decode_match: assert property ($rose(BUS_SSYN) |-> hit)
    else $error("answer to an unmatched address");
  a_answer_time: assert property ($rose(BUS_MSYN) && hit |-> s_answer)
    else $error("matched cycle not answered in time");
  a_answer_release: assert property ($fell(BUS_MSYN) |-> s_release)
    else $error("answer held too long");
  a_read_drive: assert property (BUS_SSYN |-> BUS_DATA_OE == BUS_C1)
    else $error("data drive does not follow direction");
  a_strobe_csr: assert property ($rose(BUS_SSYN) |-> CSR_WRITE_STROBE == (!BUS_C1 && !BUS_ADDR[1]))
    else $error("write strobe mismatch");
  a_buf_high: assert property (BUS_DATA_OE && BUS_ADDR[1] |-> BUS_DATA_OUT[15:8] == 8'h00)
    else $error("buffer read drives high byte");
  a_unit_lane: assert property ($changed(UNIT_SELECT) |->
    !BUS_INIT_B || (BUS_SSYN && !BUS_C1 && !BUS_ADDR[1] && (!BUS_C0 || BUS_ADDR[0])))
    else $error("drive choice changed without high lane write");
  a_gate_off: assert property (OUTBOUND_BYTE_GATE_OFF |=> OUT_BYTE == 8'h00)
    else $error("outbound byte passes while gated");
  a_launch_time: assert property (START_PULSE |-> since_wr >= 10'h1f0 && since_wr <= 10'h200)
    else $error("start pulse out of launch timing");
endmodule

// ==== cassette_ctrl_pkg.sv ====
package cassette_ctrl_pkg;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_A,
    SEQ_B,
    SEQ_C
  } seq_state_t;

  typedef enum logic {
    BUS_IDLE,
    BUS_ANSWER
  } bus_state_t;

endpackage

// ==== host_bus_master.sv ====
`timescale 1ns/1ps
`include "cassette_ctrl_defines.svh"

module host_bus_master (
  input wire logic clk,
  input wire logic ssyn,
  input wire logic [`DATA_W-1:0] rd_data,
  output logic [`ADDR_W-1:0] addr,
  output logic [`DATA_W-1:0] wr_data,
  output logic msyn,
  output logic c1,
  output logic c0
);
  initial
  begin
    addr = 18'h00000;
    wr_data = 16'h0000;
    msyn = 1'b0;
    c1 = 1'b0;
    c0 = 1'b0;
  end

  // ----------------------------------------
  // one bus cycle
  // ----------------------------------------
  task automatic xfer(input logic [17:0] a, input logic rd, input logic bt, input logic [15:0] d,
                      output logic [15:0] q, output logic ack);
    int n;
    @(posedge clk);
    #1;
    addr = a;
    c1 = rd;
    c0 = bt;
    wr_data = rd ? ~wr_data : d;
    // pins must pass the sync stage before the strobe
    repeat (3) @(posedge clk);
    #1;
    msyn = 1'b1;
    ack = 1'b0;
    n = 0;
    while (!ack && n < 12)
    begin
      @(posedge clk);
      n++;
      ack = ssyn;
    end
    q = rd_data;
    #1;
    msyn = 1'b0;
    n = 0;
    while (ssyn && n < 12)
    begin
      @(posedge clk);
      n++;
    end
    #1;
    // released lines show no stale value
    addr = ~a;
    wr_data = ~wr_data;
    c1 = ~rd;
    c0 = ~bt;
  endtask
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ps
`include "cassette_ctrl_defines.svh"

module tb_top;
  localparam logic [9:0] STRAP = 10'h2a4;
  localparam logic [17:0] CSR_A = {5'h1f, STRAP, 3'h0};
  localparam logic [17:0] BUF_A = CSR_A + 18'h00002;

  function automatic logic [127:0] mk_func();
    logic [127:0] t;
    for (int i = 0; i < 16; i++)
      t[8*i +: 8] = 8'ha0 + 8'(i);
    return t;
  endfunction

  function automatic logic [1023:0] mk_stat();
    logic [1023:0] t;
    for (int i = 0; i < 256; i++)
      t[4*i +: 4] = 4'(i) ^ 4'(i >> 4);
    return t;
  endfunction

  logic clk, rst_b, init_b, rpt, done, xreq, gate, in_valid, got, ack;
  logic [9:0] strap;
  logic [5:0] live;
  logic [4:0] xstat;
  logic [7:0] in_byte;
  logic [15:0] q;
  wire [17:0] addr;
  wire [15:0] wdata, rdata;
  wire oe, msyn, ssyn, c1, c0, in_ready, unit, strobe, start;
  wire [7:0] out_byte, func_out;
  wire [3:0] act;
  int fails, checks, n;

  host_bus_master m (.clk(clk), .ssyn(ssyn), .rd_data(rdata), .addr(addr), .wr_data(wdata), .msyn(msyn),
    .c1(c1), .c0(c0));

  cassette_ctrl_bus_registers #(.FUNC_TABLE(mk_func()), .STATUS_TABLE(mk_stat())) dut (.CLK_SYS(clk),
    .RST_B(rst_b), .BUS_ADDR(addr), .BUS_DATA_IN(wdata), .BUS_DATA_OUT(rdata), .BUS_DATA_OE(oe),
    .BUS_MSYN(msyn), .BUS_SSYN(ssyn), .BUS_C1(c1), .BUS_C0(c0), .BUS_INIT_B(init_b), .ADDR_STRAP(strap),
    .LIVE_STATUS(live), .XPORT_STATUS(xstat), .REPEAT_IN(rpt), .XPORT_DONE(done), .XFER_REQ(xreq),
    .OUTBOUND_BYTE_GATE_OFF(gate), .IN_BYTE(in_byte), .IN_VALID(in_valid), .IN_READY(in_ready),
    .OUT_BYTE(out_byte), .UNIT_SELECT(unit), .FUNC_OUT(func_out), .ACTION_EN(act),
    .CSR_WRITE_STROBE(strobe), .START_PULSE(start));

  always #4 clk = ~clk;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [3:0] stab(logic [2:0] f);
    logic [7:0] i;
    i = {xstat, f};
    return i[3:0] ^ i[7:4];
  endfunction

  function automatic logic [15:0] exp_csr(logic u, logic req, logic ie, logic rdy, logic [3:0] low);
    logic [3:0] st;
    st = stab(low[2:0]);
    return {st[3], live, u, req, ie, rdy, low, 1'b0};
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [17:0] a, input logic bt, input logic [15:0] d);
    logic [15:0] r;
    m.xfer(a, 1'b0, bt, d, r, ack);
    check("write answer", {15'h0000, ack}, 16'h0001);
  endtask

  task automatic rd(input logic [17:0] a, input logic [15:0] exp);
    m.xfer(a, 1'b1, 1'b0, 16'h0000, q, ack);
    check("read answer", {15'h0000, ack}, 16'h0001);
    check("read data", q, exp);
  endtask

  task automatic finish_test();
    if (fails == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    rst_b = 1'b0;
    init_b = 1'b1;
    strap = STRAP;
    live = 6'h2a;
    xstat = 5'h13;
    {rpt, done, xreq, gate, in_valid} = 5'h00;
    in_byte = 8'h00;
    tick(12);
    rst_b = 1'b1;
    tick(3);
    rd(CSR_A, exp_csr(1'b0, 1'b0, 1'b0, 1'b1, 4'h0));
    check("function out", {8'h00, func_out}, 16'h00a0);
    check("action", {12'h000, act}, {12'h000, stab(3'h0)});
    wr(CSR_A, 1'b0, 16'hfffe);
    live = 6'h15;
    rd(CSR_A, exp_csr(1'b1, 1'b0, 1'b1, 1'b1, 4'hf));
    check("unit", {15'h0000, unit}, 16'h0001);
    check("action", {12'h000, act}, {12'h000, stab(3'h7)});
    rpt = 1'b1;
    tick(3);
    check("function out", {8'h00, func_out}, 16'h00af);
    rpt = 1'b0;
    wr(CSR_A | 18'h00001, 1'b1, 16'h0000);
    rd(CSR_A, exp_csr(1'b0, 1'b0, 1'b1, 1'b1, 4'hf));
    wr(CSR_A, 1'b1, 16'hff00);
    rd(CSR_A, exp_csr(1'b0, 1'b0, 1'b0, 1'b1, 4'h0));
    for (int i = 0; i < 18; i++)
    begin
      if (i == 17 || i == 3 || i == 2)
      begin
        m.xfer(CSR_A ^ (18'h00001 << i), 1'b1, 1'b0, 16'h0000, q, ack);
        check("refused answer", {15'h0000, ack}, 16'h0000);
      end
    end
    wr(BUF_A, 1'b0, 16'hab5c);
    tick(2);
    check("out byte", {8'h00, out_byte}, 16'h005c);
    wr(BUF_A | 18'h00001, 1'b1, 16'h7700);
    check("out byte", {8'h00, out_byte}, 16'h005c);
    gate = 1'b1;
    tick(2);
    check("gated byte", {8'h00, out_byte}, 16'h0000);
    gate = 1'b0;
    tick(2);
    check("out byte", {8'h00, out_byte}, 16'h005c);
    xreq = 1'b1;
    tick(1);
    xreq = 1'b0;
    rd(CSR_A, exp_csr(1'b0, 1'b1, 1'b0, 1'b1, 4'h0));
    wr(BUF_A, 1'b0, 16'h005c);
    rd(CSR_A, exp_csr(1'b0, 1'b0, 1'b0, 1'b1, 4'h0));
    wr(CSR_A, 1'b0, 16'h0003);
    rd(CSR_A, exp_csr(1'b0, 1'b0, 1'b0, 1'b0, 4'h1));
    got = 1'b0;
    for (int k = 0; k < 700 && !got; k++)
    begin
      @(posedge clk);
      got = start;
    end
    check("start", {15'h0000, got}, 16'h0001);
    tick(1);
    done = 1'b1;
    tick(1);
    done = 1'b0;
    in_valid = 1'b1;
    in_byte = 8'h40;
    n = 0;
    repeat (40)
    begin
      @(posedge clk);
      if (in_ready)
        n++;
      #1;
      in_byte = 8'h40 + 8'(n);
    end
    in_valid = 1'b0;
    check("stored count", 16'(n), 16'h0012);
    for (int k = 0; k < n; k++)
      rd(BUF_A, {8'h00, 8'h40 + 8'(k)});
    rd(CSR_A, exp_csr(1'b0, 1'b0, 1'b0, 1'b1, 4'h1));
    wr(CSR_A, 1'b0, 16'h0150);
    init_b = 1'b0;
    tick(5);
    init_b = 1'b1;
    tick(3);
    check("cleared byte", {8'h00, out_byte}, 16'h0000);
    rd(CSR_A, exp_csr(1'b0, 1'b0, 1'b0, 1'b1, 4'h0));
    check("cleared bits", q & 16'h015e, 16'h0000);
    finish_test();
  end

  initial
  begin
    #(8 * 20000);
    fails++;
    finish_test();
  end
endmodule

bind cassette_ctrl_bus_registers cassette_ctrl_monitor mon (.CLK_SYS(CLK_SYS), .RST_B(RST_B),
  .BUS_ADDR(BUS_ADDR), .BUS_DATA_OUT(BUS_DATA_OUT), .BUS_DATA_OE(BUS_DATA_OE), .BUS_MSYN(BUS_MSYN),
  .BUS_SSYN(BUS_SSYN), .BUS_C1(BUS_C1), .BUS_C0(BUS_C0), .BUS_INIT_B(BUS_INIT_B), .ADDR_STRAP(ADDR_STRAP),
  .OUTBOUND_BYTE_GATE_OFF(OUTBOUND_BYTE_GATE_OFF), .OUT_BYTE(OUT_BYTE), .UNIT_SELECT(UNIT_SELECT),
  .CSR_WRITE_STROBE(CSR_WRITE_STROBE), .START_PULSE(START_PULSE));
